// ### core/byte_fifo.v
`timescale 1ns/1ps
// small synchronous fifo with valid/ready on both sides
module byte_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire             i_mclk,
   input  wire             i_rst_n,
   input  wire             i_clear,
   input  wire             i_in_valid,
   output wire             o_in_ready,
   input  wire [WIDTH-1:0] i_in_data,
   output wire             o_out_valid,
   input  wire             i_out_ready,
   output wire [WIDTH-1:0] o_out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1]; // storage
   reg [AW-1:0]    wr_q;            // write pointer
   reg [AW-1:0]    rd_q;            // read pointer
   reg [AW:0]      cnt_q;           // occupancy
   wire            push;
   wire            pop;

   // honest flags from the occupancy count
   assign o_in_ready  = (cnt_q != DEPTH[AW:0]);
   assign o_out_valid = (cnt_q != {(AW+1){1'b0}});
   assign o_out_data  = mem[rd_q];
   assign push        = i_in_valid & o_in_ready;
   assign pop         = o_out_valid & i_out_ready;

   // storage write, no reset needed on data
   always @(posedge i_mclk) begin
      if (push) begin
         mem[wr_q] <= i_in_data;
      end
   end

   // pointers and count
   always @(posedge i_mclk) begin
      if (!i_rst_n || i_clear) begin
         wr_q  <= {AW{1'b0}};
         rd_q  <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule

// ### core/mouse_sensor_defs.vh
`ifndef MOUSE_SENSOR_DEFS_VH
`define MOUSE_SENSOR_DEFS_VH

// register offsets (7-bit serial address space)
`define OFF_DIAG_RESULT_FIRST   7'h0C
`define OFF_DIAG_RESULT_SECOND  7'h0D
`define OFF_DIAG_RESULT_THIRD   7'h0E
`define OFF_DIAG_RESULT_FOURTH  7'h0F
`define OFF_DIAG_START_CONTROL  7'h10
`define OFF_SENSOR_SETUP        7'h11
`define OFF_FRAME_ACTIVITY_MON  7'h2E
`define OFF_SOFT_RESET_KEY      7'h3A
`define OFF_COMPLEMENT_REV      7'h3E
`define OFF_COMPLEMENT_PART     7'h3F
`define OFF_BURST_READOUT       7'h42

// healthy self-test signature bytes
`define SIG_FIRST               8'hAF
`define SIG_SECOND              8'h4E
`define SIG_THIRD               8'h31
`define SIG_FOURTH              8'h22

// field positions and values
`define DIAG_TRIGGER_BIT        0
`define CPI_SELECT_BIT          7
`define SLEEP_FORCE_HI          5
`define SLEEP_FORCE_LO          4
`define SETUP_RESET             8'h03
`define SOFT_RESET_KEY_VAL      8'h5A
`define FRAME_FLAGS_ALL         4'hF
`define MOTION_FLAG_BIT         7

// burst framing
`define BURST_BYTES             3'd7
`define BURST_CLEAR_AFTER       3'd3

// self-test duration
`define MCLK_HZ                 125000000
`define SELFTEST_TIME_MS        250
`define SELFTEST_CYCLES         (`SELFTEST_TIME_MS * (`MCLK_HZ / 1000))

`endif

// ### core/mouse_sensor_regs.v
`timescale 1ns/1ps
`include "mouse_sensor_defs.vh"
module mouse_sensor_regs #(
   parameter        ST_CYCLES = `SELFTEST_CYCLES,
   parameter        ST_W      = 25,
   parameter [7:0]  REV_CODE  = 8'h11,  // arbitrary value
   parameter [7:0]  PART_CODE = 8'h24,  // arbitrary value
   parameter        FIFO_DEPTH = 16
) (
   input  wire        i_mclk,
   input  wire        i_rst_n,
   input  wire        i_ncs_n,
   input  wire        i_sclk,
   input  wire        i_mosi,
   output wire        o_miso,
   output wire        o_miso_oe,
   input  wire        i_frame_tick,
   input  wire [7:0]  i_frame_dx,
   input  wire [7:0]  i_frame_dy,
   input  wire [7:0]  i_squal,
   input  wire [15:0] i_shutter,
   input  wire [7:0]  i_max_pixel,
   input  wire [1:0]  i_power_state,
   output wire        o_cpi_800,
   output wire [1:0]  o_sleep_force,
   output wire        o_selftest_busy,
   output wire        o_tracking_en
);
   // saturating signed add of a frame delta into an accumulator
   function [7:0] sat_add;
      input [7:0] acc;
      input [7:0] inc;
      reg   [8:0] sum;
      begin
         sum = {acc[7], acc} + {inc[7], inc};
         if (sum[8] != sum[7]) begin
            sat_add = sum[8] ? 8'h80 : 8'h7F;
         end else begin
            sat_add = sum[7:0];
         end
      end
   endfunction

   // halve a signed delta when running at the lower resolution
   function [7:0] scale_delta;
      input [7:0] d;
      input       hi_res;
      begin
         scale_delta = hi_res ? d : {d[7], d[7:1]};
      end
   endfunction

   // pin synchronisers, two flops each
   // the link clock is sampled, never used as a clock, so its high and
   // low phases must each last several i_mclk periods to be seen
   reg  [1:0] ncs_s_q;   // chip select
   reg  [1:0] sclk_s_q;  // serial clock
   reg  [1:0] mosi_s_q;  // serial data in
   reg        sclk_d_q;  // last synced clock, for edges
   wire       sel;
   wire       sclk_rise;
   wire       sclk_fall;

   // internal reset: pin reset or the keyed soft reset
   reg        soft_rst_q;
   wire       rst_all;
   assign rst_all = ~i_rst_n | soft_rst_q;

   // register state
   reg  [7:0] setup_q;      // sensor setup byte
   reg  [3:0] tick_q;       // frame tick flags
   reg  [7:0] acc_dx_q;     // accumulated x motion
   reg  [7:0] acc_dy_q;     // accumulated y motion
   reg        st_busy_q;    // self-test running
   reg        st_done_q;    // self-test finished, results valid
   reg  [ST_W-1:0] st_cnt_q;

   // serial engine state
   reg  [2:0] bit_q;        // bit within byte
   reg  [7:0] rx_q;         // incoming shift register
   reg  [7:0] tx_q;         // outgoing shift register
   reg        addr_ph_q;    // first byte of a frame still pending
   reg        wr_q;         // frame is a write
   reg        burst_q;      // frame is a burst read
   reg  [6:0] addr_q;       // latched address
   reg  [2:0] bcnt_q;       // burst bytes loaded
   reg  [2:0] fill_q;       // burst bytes pushed
   reg        filling_q;    // burst snapshot in progress

   // fifo wires
   // deeper than one burst, so the fill never waits in practice
   wire       f_in_ready;
   wire       f_out_valid;
   wire [7:0] f_out_data;
   reg  [7:0] f_in_data;
   wire       f_pop;
   wire [1:0] power_state;

   assign sel       = ~ncs_s_q[1];
   assign sclk_rise = sel & sclk_s_q[1] & ~sclk_d_q;
   assign sclk_fall = sel & ~sclk_s_q[1] & sclk_d_q;
   assign o_miso    = tx_q[7];
   assign o_miso_oe = sel;
   assign o_cpi_800     = setup_q[`CPI_SELECT_BIT];
   assign o_sleep_force = setup_q[`SLEEP_FORCE_HI:`SLEEP_FORCE_LO];
   assign o_selftest_busy = st_busy_q;
   // tracking stays halted after a self-test until a reset
   assign o_tracking_en = ~st_busy_q & ~st_done_q;
   // forced sleep overrides the automatic power state in the report
   assign power_state = (o_sleep_force != 2'b00) ? o_sleep_force : i_power_state;

   // byte boundary: load at first falling edge of a data byte
   wire load_slot = sclk_fall & ~addr_ph_q & ~wr_q & (bit_q == 3'd0);
   assign f_pop   = load_slot & burst_q;

   // synchronise pins; reset only to constants
   always @(posedge i_mclk) begin
      if (!i_rst_n) begin
         ncs_s_q  <= 2'b11;
         sclk_s_q <= 2'b11;
         mosi_s_q <= 2'b00;
         sclk_d_q <= 1'b1;
      end else begin
         ncs_s_q  <= {ncs_s_q[0], i_ncs_n};
         sclk_s_q <= {sclk_s_q[0], i_sclk};
         mosi_s_q <= {mosi_s_q[0], i_mosi};
         sclk_d_q <= sclk_s_q[1];
      end
   end

   // read data for single-register reads
   reg [7:0] rd_data;
   always @* begin
      rd_data = 8'h00;
      case (addr_q)
         `OFF_DIAG_RESULT_FIRST:  rd_data = st_done_q ? `SIG_FIRST : 8'h00;
         `OFF_DIAG_RESULT_SECOND: rd_data = st_done_q ? `SIG_SECOND : 8'h00;
         `OFF_DIAG_RESULT_THIRD:  rd_data = st_done_q ? `SIG_THIRD : 8'h00;
         `OFF_DIAG_RESULT_FOURTH: rd_data = st_done_q ? `SIG_FOURTH : 8'h00;
         `OFF_SENSOR_SETUP:       rd_data = setup_q;
         `OFF_FRAME_ACTIVITY_MON: rd_data = {2'b00, power_state, tick_q};
         `OFF_COMPLEMENT_REV:     rd_data = ~REV_CODE;
         `OFF_COMPLEMENT_PART:    rd_data = ~PART_CODE;
         default:                 rd_data = 8'h00;
      endcase
      // a stray read during the test sees zeros, never half-built results
      // results are withheld while the test runs
      if (st_busy_q) begin
         rd_data = 8'h00;
      end
   end

   // snapshot byte selector for the burst stream, in transmit order
   always @* begin
      f_in_data = 8'h00;
      case (fill_q)
         3'd0:    f_in_data = {(acc_dx_q != 8'h00) | (acc_dy_q != 8'h00), 7'h00};
         3'd1:    f_in_data = acc_dy_q;
         3'd2:    f_in_data = acc_dx_q;
         3'd3:    f_in_data = i_squal;
         3'd4:    f_in_data = i_shutter[15:8];
         3'd5:    f_in_data = i_shutter[7:0];
         3'd6:    f_in_data = i_max_pixel;
         default: f_in_data = 8'h00;
      endcase
   end

   // snapshot taken right after the address byte, so all seven bytes
   // describe one instant even when the link drains them slowly
   // burst staging buffer; fill stalls when it is full
   byte_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH),
      .AW    (4)
   ) u_burst_fifo (
      .i_mclk      (i_mclk),
      .i_rst_n     (~rst_all),
      .i_clear     (~sel),
      .i_in_valid  (filling_q),
      .o_in_ready  (f_in_ready),
      .i_in_data   (f_in_data),
      .o_out_valid (f_out_valid),
      .i_out_ready (f_pop),
      .o_out_data  (f_out_data)
   );

   // a frame may be cut anywhere; deselect rewinds to the address phase
   // serial engine: sample on rising, shift out on falling (mode 3)
   reg        byte_done;
   reg [7:0]  rx_byte;
   always @* begin
      rx_byte   = {rx_q[6:0], mosi_s_q[1]};
      byte_done = sclk_rise & (bit_q == 3'd7);
   end

   always @(posedge i_mclk) begin
      if (rst_all || !sel) begin
         // frame boundary drops any half-sent byte
         bit_q     <= 3'd0;
         rx_q      <= 8'h00;
         tx_q      <= 8'h00;
         addr_ph_q <= 1'b1;
         wr_q      <= 1'b0;
         burst_q   <= 1'b0;
         addr_q    <= 7'h00;
         bcnt_q    <= 3'd0;
      end else begin
         if (sclk_rise) begin
            rx_q  <= rx_byte;
            bit_q <= bit_q + 3'd1;
         end
         // address byte decides the frame kind
         if (byte_done && addr_ph_q) begin
            addr_ph_q <= 1'b0;
            wr_q      <= rx_byte[7];
            addr_q    <= rx_byte[6:0];
            burst_q   <= ~rx_byte[7] & (rx_byte[6:0] == `OFF_BURST_READOUT);
         end
         // outgoing byte: fresh load at the boundary, else shift
         if (load_slot) begin
            if (burst_q) begin
               tx_q   <= f_out_valid ? f_out_data : 8'h00;
               bcnt_q <= (bcnt_q == `BURST_BYTES) ? bcnt_q : bcnt_q + 3'd1;
            end else begin
               tx_q <= rd_data;
            end
         end else if (sclk_fall) begin
            tx_q <= {tx_q[6:0], 1'b0};
         end
      end
   end

   // one byte staged per cycle, far faster than the link drains them
   // burst snapshot fill, paced by fifo ready
   always @(posedge i_mclk) begin
      if (rst_all || !sel) begin
         fill_q    <= 3'd0;
         filling_q <= 1'b0;
      end else if (byte_done && addr_ph_q && !rx_byte[7]
                   && rx_byte[6:0] == `OFF_BURST_READOUT && !st_busy_q) begin
         fill_q    <= 3'd0;
         filling_q <= 1'b1;
      end else if (filling_q && f_in_ready) begin
         fill_q    <= fill_q + 3'd1;
         filling_q <= (fill_q != `BURST_BYTES - 3'd1);
      end
   end

   // write decode, taken when the data byte completes
   wire wr_strobe = byte_done & ~addr_ph_q & wr_q & ~st_busy_q;
   // clear motion after the third burst byte has been shifted out
   wire burst_clr = byte_done & burst_q & (bcnt_q == `BURST_CLEAR_AFTER);

   // a wrong key is dropped; only the exact value resets the bank
   // keyed soft reset: one-cycle pulse into the internal reset
   always @(posedge i_mclk) begin
      if (!i_rst_n) begin
         soft_rst_q <= 1'b0;
      end else begin
         soft_rst_q <= wr_strobe & (addr_q == `OFF_SOFT_RESET_KEY)
                       & (rx_byte == `SOFT_RESET_KEY_VAL);
      end
   end

   // sensor setup register
   always @(posedge i_mclk) begin
      if (rst_all) begin
         setup_q <= `SETUP_RESET;
      end else if (wr_strobe && addr_q == `OFF_SENSOR_SETUP) begin
         setup_q <= rx_byte;
      end
   end

   // frame flags: a frame tick wins over a simultaneous clear
   always @(posedge i_mclk) begin
      if (rst_all) begin
         tick_q <= 4'h0;
      end else if (i_frame_tick) begin
         tick_q <= `FRAME_FLAGS_ALL;
      end else if (wr_strobe && addr_q == `OFF_FRAME_ACTIVITY_MON) begin
         tick_q <= 4'h0;
      end
   end

   // the count width must hold the full duration at the system clock
   // self-test timer; the sensor is deaf to the port meanwhile
   always @(posedge i_mclk) begin
      if (rst_all) begin
         st_busy_q <= 1'b0;
         st_done_q <= 1'b0;
         st_cnt_q  <= {ST_W{1'b0}};
      end else if (st_busy_q) begin
         if (st_cnt_q == ST_CYCLES[ST_W-1:0] - 1'b1) begin
            st_busy_q <= 1'b0;
            st_done_q <= 1'b1;
         end else begin
            st_cnt_q <= st_cnt_q + 1'b1;
         end
      end else if (wr_strobe && addr_q == `OFF_DIAG_START_CONTROL
                   && rx_byte[`DIAG_TRIGGER_BIT]) begin
         st_busy_q <= 1'b1;
         st_done_q <= 1'b0;
         st_cnt_q  <= {ST_W{1'b0}};
      end
   end

   // saturation keeps a long unread run from wrapping to the other sign
   // halving at the lower resolution happens before accumulation
   // motion accumulators; a new frame delta survives a clear
   always @(posedge i_mclk) begin
      if (rst_all) begin
         acc_dx_q <= 8'h00;
         acc_dy_q <= 8'h00;
      end else if (i_frame_tick && o_tracking_en) begin
         acc_dx_q <= sat_add(burst_clr ? 8'h00 : acc_dx_q,
                             scale_delta(i_frame_dx, o_cpi_800));
         acc_dy_q <= sat_add(burst_clr ? 8'h00 : acc_dy_q,
                             scale_delta(i_frame_dy, o_cpi_800));
      end else if (burst_clr) begin
         acc_dx_q <= 8'h00;
         acc_dy_q <= 8'h00;
      end
   end
endmodule

// ### tb/mouse_sensor_regs_chk.sv
`timescale 1ns/1ps
// port-level checker for the sensor register bank
module mouse_sensor_regs_chk #(
   parameter ST_CYCLES = 200
) (
   input wire       i_mclk,
   input wire       i_rst_n,
   input wire       i_ncs_n,
   input wire       o_miso_oe,
   input wire       o_cpi_800,
   input wire [1:0] o_sleep_force,
   input wire       o_selftest_busy,
   input wire       o_tracking_en
);
   reg [31:0] busy_run_q;   // cycles busy has stood high so far
   // run length of busy, so its full span is checked without long repetitions
   always @(posedge i_mclk) begin
      if (!i_rst_n) begin
         busy_run_q <= 32'h0;
      end else if (o_selftest_busy) begin
         busy_run_q <= busy_run_q + 32'h1;
      end else begin
         busy_run_q <= 32'h0;
      end
   end
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   a_reset_defaults: assert property (
      $rose(i_rst_n) |-> !o_cpi_800 && o_sleep_force == 2'h0 && !o_selftest_busy && o_tracking_en)
      else $error("outputs not at defaults after reset");
   a_cpi_in_frame: assert property (
      $changed(o_cpi_800) |-> !i_ncs_n)
      else $error("resolution changed outside a serial frame");
   a_sleep_in_frame: assert property (
      $changed(o_sleep_force) |-> !i_ncs_n)
      else $error("sleep field changed outside a serial frame");
   a_oe_active: assert property (
      !i_ncs_n [*5] |-> o_miso_oe)
      else $error("data out not driven while selected");
   a_oe_idle: assert property (
      i_ncs_n [*5] |-> !o_miso_oe)
      else $error("data out driven while deselected");
   a_track_off: assert property (
      o_selftest_busy |-> !o_tracking_en)
      else $error("tracking enabled during self-test");
   a_busy_len: assert property (
      $fell(o_selftest_busy) |-> busy_run_q == ST_CYCLES)
      else $error("self-test length wrong");
   a_busy_start: assert property (
      $rose(o_selftest_busy) |-> !i_ncs_n ##1 !o_tracking_en)
      else $error("self-test started without a serial write");
   a_cfg_frozen: assert property (
      o_selftest_busy |-> $stable(o_cpi_800) && $stable(o_sleep_force))
      else $error("setup changed during self-test");
   c_test_done: cover property ($fell(o_selftest_busy));
   c_sleep_three: cover property (o_sleep_force == 2'h3);
   c_cpi_high: cover property ($rose(o_cpi_800));
endmodule

bind mouse_sensor_regs mouse_sensor_regs_chk #(.ST_CYCLES(ST_CYCLES)) mouse_sensor_regs_chk_i (
   .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ncs_n(i_ncs_n), .o_miso_oe(o_miso_oe),
   .o_cpi_800(o_cpi_800), .o_sleep_force(o_sleep_force),
   .o_selftest_busy(o_selftest_busy), .o_tracking_en(o_tracking_en));

// ### tb/spi_master_model.sv
`timescale 1ns/1ps
// mode 3 serial controller, every pin moved on an i_mclk rising edge
module spi_master_model (
   input  wire       i_mclk,
   input  wire       i_miso,
   input  wire       i_miso_oe,
   output reg        o_ncs_n,
   output reg        o_sclk,
   output reg        o_mosi,
   output reg  [7:0] o_rx,
   output reg        o_rx_vld
);
   reg  last_q;                              // last level seen driven
   wire seen = i_miso_oe ? i_miso : ~last_q; // released line never shows stale data
   initial begin
      o_ncs_n = 1'h1;
      o_sclk = 1'h1;
      o_mosi = 1'h0;
      o_rx = 8'h00;
      o_rx_vld = 1'h0;
      last_q = 1'h0;
   end
   // remember the driven level
   always @(posedge i_mclk) begin
      if (i_miso_oe) begin
         last_q <= i_miso;
      end
   end
   task start;
      @(posedge i_mclk);
      o_ncs_n <= 1'h0;
      repeat (4) @(posedge i_mclk);
   endtask
   // one byte, msb first; sampled late in the high phase for margin
   task xb(input [7:0] tx, input want);
      integer i;
      for (i = 7; i >= 0; i--) begin
         @(posedge i_mclk);
         o_rx_vld <= 1'h0;
         o_sclk <= 1'h0;
         o_mosi <= tx[i];
         repeat (4) @(posedge i_mclk);
         o_sclk <= 1'h1;
         repeat (3) @(posedge i_mclk);
         o_rx[i] <= seen;
      end
      o_rx_vld <= want;
   endtask
   // select held well past the last edge, then a gap before the next frame
   task stop;
      @(posedge i_mclk);
      o_rx_vld <= 1'h0;
      repeat (7) @(posedge i_mclk);
      o_ncs_n <= 1'h1;
      repeat (6) @(posedge i_mclk);
   endtask
endmodule

// ### tb/tb_mouse_sensor_regs.sv
`timescale 1ns/1ps
`include "mouse_sensor_defs.vh"
module tb_mouse_sensor_regs;
   localparam [7:0] REV = 8'h3C;   // arbitrary value
   localparam [7:0] PART = 8'h5D;  // arbitrary value
   typedef struct {string nm; logic [7:0] e; logic [7:0] m;} note_t;
   note_t       q[$];                 // expected serial bytes, oldest first
   logic        mclk = 1'h0;
   logic        rst_n, tick;
   logic [7:0]  fdx, fdy, squal, maxp, be[0:9], bm[0:9];
   logic [15:0] shut;
   logic [1:0]  pst;
   wire         ncs_n, sclk, mosi, miso, oe, cpi, busy, track, rx_vld;
   wire  [1:0]  slp;
   wire  [7:0]  rx;
   integer      seed, error_cnt, n_checks, cyc, k, n, ix, iy;
   note_t       nt;
   always #4 mclk = ~mclk;
   mouse_sensor_regs #(.ST_CYCLES(200), .REV_CODE(REV), .PART_CODE(PART)) mouse_sensor_regs_i (
      .i_mclk(mclk), .i_rst_n(rst_n), .i_ncs_n(ncs_n), .i_sclk(sclk), .i_mosi(mosi),
      .o_miso(miso), .o_miso_oe(oe), .i_frame_tick(tick), .i_frame_dx(fdx), .i_frame_dy(fdy),
      .i_squal(squal), .i_shutter(shut), .i_max_pixel(maxp), .i_power_state(pst),
      .o_cpi_800(cpi), .o_sleep_force(slp), .o_selftest_busy(busy), .o_tracking_en(track));
   spi_master_model spi_master_model_i (.i_mclk(mclk), .i_miso(miso), .i_miso_oe(oe),
      .o_ncs_n(ncs_n), .o_sclk(sclk), .o_mosi(mosi), .o_rx(rx), .o_rx_vld(rx_vld));
   task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task give_verdict;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task note(input string nm, input logic [7:0] e, input logic [7:0] m);
      q.push_back('{nm, e & m, m});
   endtask
   task wr(input [6:0] a, input [7:0] d);
      spi_master_model_i.start;
      spi_master_model_i.xb({1'h1, a}, 1'h0);
      spi_master_model_i.xb(d, 1'h0);
      spi_master_model_i.stop;
   endtask
   task rd(input [6:0] a, input [7:0] e, input [7:0] m, input string nm);
      spi_master_model_i.start;
      spi_master_model_i.xb({1'h0, a}, 1'h0);
      note(nm, e, m);
      spi_master_model_i.xb(8'h00, 1'h1);
      spi_master_model_i.stop;
   endtask
   // burst of n bytes against be/bm
   task burst(input integer cnt);
      integer j;
      spi_master_model_i.start;
      spi_master_model_i.xb({1'h0, `OFF_BURST_READOUT}, 1'h0);
      for (j = 0; j < cnt; j++) begin
         note("burst", be[j], bm[j]);
         spi_master_model_i.xb(8'h00, 1'h1);
      end
      spi_master_model_i.stop;
   endtask
   task frame(input [7:0] x, input [7:0] y);
      @(posedge mclk);
      tick <= 1'h1;
      fdx <= x;
      fdy <= y;
      @(posedge mclk);
      tick <= 1'h0;
   endtask
   // scoreboard: each byte the controller flags valid is matched to the oldest note
   always @(posedge mclk) begin
      if (rx_vld === 1'h1) begin
         if (q.size() == 0) chk("unexpected byte", 8'h00, 8'hFF);
         else begin
            nt = q.pop_front();
            chk(nt.nm, nt.e, rx & nt.m);
         end
      end
   end
   // hang guard
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 60000) begin
         error_cnt++;
         give_verdict;
      end
   end
   initial begin
      {error_cnt, n_checks, cyc, seed} = {32'h0, 32'h0, 32'h0, 32'd69198};
      {rst_n, tick, fdx, fdy, squal, maxp, shut, pst} = 0;
      repeat (3) @(posedge mclk);
      rst_n <= 1'h1;
      repeat (4) @(posedge mclk);
      chk("pins", 8'h01, {3'h0, cpi, slp, busy, track});
      rd(`OFF_SENSOR_SETUP, `SETUP_RESET, 8'hFF, "setup");
      rd(`OFF_COMPLEMENT_REV, ~REV, 8'hFF, "rev");
      wr(`OFF_COMPLEMENT_PART, 8'h00);
      rd(`OFF_COMPLEMENT_PART, ~PART, 8'hFF, "part");
      rd(`OFF_DIAG_RESULT_FIRST, 8'h00, 8'hFF, "no test yet");
      for (k = 0; k < 4; k++) begin
         pst <= 2'($random(seed));
         wr(`OFF_SENSOR_SETUP, {k[0], 1'h0, k[1:0], 4'h0});
         chk("cpi", {7'h00, k[0]}, {7'h00, cpi});
         chk("sleep", {6'h00, k[1:0]}, {6'h00, slp});
         rd(`OFF_SENSOR_SETUP, {k[0], 1'h0, k[1:0], 4'h0}, 8'hFF, "setup");
         rd(`OFF_FRAME_ACTIVITY_MON, {2'h0, k[1:0] ? k[1:0] : pst, 4'h0}, 8'h30, "mode");
      end
      wr(`OFF_FRAME_ACTIVITY_MON, 8'h00);
      rd(`OFF_FRAME_ACTIVITY_MON, 8'h00, 8'h0F, "flags");
      frame(8'h00, 8'h00);
      rd(`OFF_FRAME_ACTIVITY_MON, `FRAME_FLAGS_ALL, 8'h0F, "flags");
      wr(`OFF_FRAME_ACTIVITY_MON, 8'h00);
      rd(`OFF_FRAME_ACTIVITY_MON, 8'h00, 8'h0F, "flags");
      for (k = 0; k < 10; k++) {be[k], bm[k]} = {8'h00, 8'hFF};
      bm[0] = 8'h00;
      burst(3);
      wr(`OFF_SENSOR_SETUP, 8'h80);
      {squal, maxp, shut} <= $random(seed);
      ix = $random(seed) % 51;
      iy = $random(seed) % 51;
      frame(ix[7:0], iy[7:0]);
      be[2] = ix[7:0];
      be[1] = iy[7:0];
      ix = $random(seed) % 51;
      iy = $random(seed) % 51;
      frame(ix[7:0], iy[7:0]);
      {be[0], be[1], be[2]} = {8'h80, be[1] + iy[7:0], be[2] + ix[7:0]};
      {be[3], be[4], be[5], be[6]} = {squal, shut, maxp};
      bm[0] = 8'h80;
      burst(8);
      {be[0], be[1], be[2]} = 24'h0;
      burst(3);
      wr(`OFF_SENSOR_SETUP, 8'h00);
      ix = ($random(seed) % 26) * 2;
      iy = ($random(seed) % 26) * 2;
      frame(ix[7:0], iy[7:0]);
      ix = ix / 2;
      iy = iy / 2;
      {be[0], be[1], be[2]} = {8'h80, iy[7:0], ix[7:0]};
      burst(3);
      wr(`OFF_DIAG_START_CONTROL, 8'h00);
      chk("busy", 8'h00, {7'h00, busy});
      wr(`OFF_DIAG_START_CONTROL, 8'h01);
      chk("busy track", 8'h02, {6'h00, busy, track});
      for (k = 0; k < 400 && busy !== 1'h0; k++) @(posedge mclk);
      chk("busy", 8'h00, {7'h00, busy});
      rd(`OFF_DIAG_RESULT_FIRST, `SIG_FIRST, 8'hFF, "diag");
      rd(`OFF_DIAG_RESULT_SECOND, `SIG_SECOND, 8'hFF, "diag");
      rd(`OFF_DIAG_RESULT_THIRD, `SIG_THIRD, 8'hFF, "diag");
      rd(`OFF_DIAG_RESULT_FOURTH, `SIG_FOURTH, 8'hFF, "diag");
      chk("track", 8'h00, {7'h00, track});
      wr(`OFF_SENSOR_SETUP, 8'hB0);
      wr(`OFF_SOFT_RESET_KEY, 8'h5B);
      rd(`OFF_SENSOR_SETUP, 8'hB0, 8'hFF, "setup");
      wr(`OFF_SOFT_RESET_KEY, `SOFT_RESET_KEY_VAL);
      chk("pins", 8'h01, {3'h0, cpi, slp, busy, track});
      rd(`OFF_SENSOR_SETUP, `SETUP_RESET, 8'hFF, "setup");
      rd(`OFF_DIAG_RESULT_FIRST, 8'h00, 8'hFF, "diag cleared");
      // a long burst drains the staging buffer; bytes past the seventh read zero
      {squal, maxp, shut} <= $random(seed);
      frame(8'h06, 8'hFA);
      {be[0], be[1], be[2]} = {8'h80, 8'hFD, 8'h03};
      {be[3], be[4], be[5], be[6]} = {squal, shut, maxp};
      burst(10);
      chk("notes left", 8'h00, 8'(q.size()));
      chk("oe idle", 8'h00, {7'h00, oe});
      repeat (4) @(posedge mclk);
      give_verdict;
   end
endmodule
